// File: hdl/adc_cal_cfg.svh
/*
 * Constants for the calibration reset sequencer: register map, field
 * positions, output pattern, pipeline depth and calibration timing.
 * Assumes it is included by bare name from every design file that needs it.
 */
`ifndef ADC_CAL_CFG_SVH
`define ADC_CAL_CFG_SVH

// Status register address and its fields.
`define CAL_STATUS_ADDR   8'hB6
`define CAL_DONE_BIT      0
`define STRAP_ILL_BIT     1
`define DIV2_MODE_BIT     2
`define CAL_STATUS_RST    8'h00

// Output word shown while calibration runs, and output width.
`define CAL_PATTERN       16'hCCCC
`define DATA_W            16
`define SAMPLE_W          12

// Conversion latency in sample clock cycles.
`define PIPE_LATENCY      20

// Clock rate and calibration times.
`define CLK_MHZ           200
`define CAL_NOM_MS        200
`define CAL_MAX_MS        550
`define CAL_NOM_CYC       (`CAL_NOM_MS * `CLK_MHZ * 1000)
`define CAL_MAX_CYC       (`CAL_MAX_MS * `CLK_MHZ * 1000)
`define CAL_CNT_W         27

// Divider strap codes as seen on the two strap sense inputs.
`define STRAP_TIED_LOW    2'h0
`define STRAP_FLOATING    2'h1
`define STRAP_TIED_HIGH   2'h2

`endif

// File: hdl/adc_cal_pkg.sv
/*
 * Types and shared helpers for the calibration reset sequencer.
 * Assumes the constants header is available on the include path.
 */
package adc_cal_pkg;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_POR  = 2'b00,
        ST_HOLD = 2'b01,
        ST_CAL  = 2'b10,
        ST_RUN  = 2'b11
    } seq_state_t;

    // Clock divider selection.
    typedef enum logic {
        DIV_BY1 = 1'b0,
        DIV_BY2 = 1'b1
    } div_mode_t;

    // Detects a rising edge between two samples of a level.
    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction

    // Detects a falling edge between two samples of a level.
    function automatic logic fall(input logic prev, input logic cur);
        fall = prev & ~cur;
    endfunction

endpackage

// File: hdl/cal_link_if.sv
/*
 * Interface between the sequencer and its calibration timer.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/10ps

interface cal_link_if;
    logic start;  // One-cycle pulse that begins a calibration.
    logic abort;  // One-cycle pulse that cancels a running calibration.
    logic busy;   // High while calibration runs.
    logic done;   // One-cycle pulse when calibration finishes.

    // Sequencer side.
    modport seq (output start, output abort, input busy, input done);
    // Timer side.
    modport timer (input start, input abort, output busy, output done);
endinterface

// File: hdl/cal_timer.sv
/*
 * Calibration timer: runs the core self-calibration interval.
 * Assumes start and abort come from logic on the same clock.
 */
`timescale 1ns/10ps
`include "adc_cal_cfg.svh"

module cal_timer
    import adc_cal_pkg::*;
#(
    parameter int NOM_CYC = `CAL_NOM_CYC,
    parameter int MAX_CYC = `CAL_MAX_CYC
) (
    // Clock and reset.
    input  wire logic     clk_in,
    input  wire logic     rst_n_in,
    // Sequencer link.
    cal_link_if.timer     link
);

    // The interval ends at the nominal time but never past the maximum.
    localparam int END_CYC = (NOM_CYC < MAX_CYC) ? NOM_CYC : MAX_CYC;
    localparam logic [`CAL_CNT_W-1:0] END_CNT = END_CYC[`CAL_CNT_W-1:0] - 1'b1;

    logic [`CAL_CNT_W-1:0] cnt_ff;   // Cycles elapsed in this calibration.
    logic                  busy_ff;  // Calibration running.
    logic                  done_ff;  // Completion pulse.

    // Counts the interval; abort wins over everything but reset and a start restarts.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (link.abort) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (link.start) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
        end else if (busy_ff && cnt_ff == END_CNT) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
        end else begin
            cnt_ff  <= busy_ff ? cnt_ff + 1'b1 : cnt_ff;
            done_ff <= 1'b0;
        end
    end

    assign link.busy = busy_ff;
    assign link.done = done_ff;

endmodule // cal_timer

// File: hdl/sample_pipe.sv
/*
 * Conversion pipeline: delays each sample by the fixed latency.
 * Assumes tick marks one sample clock period of the cores.
 */
`timescale 1ns/10ps
`include "adc_cal_cfg.svh"

module sample_pipe
    import adc_cal_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    // Sample stream.
    input  wire logic                 tick_in,
    input  wire logic [`SAMPLE_W-1:0] sample_in,
    output logic      [`SAMPLE_W-1:0] sample_out
);

    // One stage per cycle of latency.
    logic [`SAMPLE_W-1:0] stage_ff [0:`PIPE_LATENCY-1];

    // Shifts the whole pipe by one stage on every sample tick.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < `PIPE_LATENCY; i++) begin
                stage_ff[i] <= '0;
            end
        end else if (tick_in) begin
            stage_ff[0] <= sample_in;
            for (int i = 1; i < `PIPE_LATENCY; i++) begin
                stage_ff[i] <= stage_ff[i-1];
            end
        end
    end

    assign sample_out = stage_ff[`PIPE_LATENCY-1];

endmodule // sample_pipe

// File: hdl/adc_calibration_reset_seq.sv
/*
 * Start-up and user calibration sequencer of a two-core interleaved
 * converter: drives the open-drain recalibration line during supply-up,
 * runs the calibration timer, shapes data and output strobe, and answers
 * status reads.
 * Assumes the supply detector, strap sense and phase-slip pins are
 * asynchronous, and the register read port is driven on this clock.
 */
`timescale 1ns/10ps
`include "adc_cal_cfg.svh"

// Overview of operation
// - samples leave twenty-one sample cycles after entry
// - cores sampled on alternating sample edges
// - hold recal line low until supplies good
// - each recal rising edge starts calibration
// - status bit zero during calibration, one after
// - data shows CCCC pattern while calibrating
// - strobe pair low while recal line low
// - strobe resumes at first edge after release
// - calibration ends nominally, never past maximum
// - device pulls recal low; host may too
// - strap low divides two, float one, high illegal
// - divide-by-two mode allows edge-skip synchronisation
module adc_calibration_reset_seq
    import adc_cal_pkg::*;
#(
    parameter int CAL_NOM_CYC = `CAL_NOM_CYC,
    parameter int CAL_MAX_CYC = `CAL_MAX_CYC
) (
    // Clock and reset.
    input  wire logic                 CLK_IN,
    input  wire logic                 RST_N_IN,
    // Supply detector levels.
    input  wire logic                 ANALOG_SUPPLY_OK_IN,
    input  wire logic                 DIGITAL_SUPPLY_OK_IN,
    // Open-drain recalibration line.
    input  wire logic                 RECAL_REQUEST_N_IN,
    output logic                      RECAL_REQUEST_N_OUT,
    output logic                      RECAL_REQUEST_N_OE_OUT,
    // Divider strap sense and edge-skip request.
    input  wire logic [1:0]           DIVIDER_STRAP_IN,
    input  wire logic                 PHASE_SLIP_IN,
    // Core sampling.
    input  wire logic [`SAMPLE_W-1:0] SAMPLE_IN,
    output logic                      CORE_A_SAMPLE_OUT,
    output logic                      CORE_B_SAMPLE_OUT,
    // Output data, strobe pair and strap fault flag.
    output logic [`DATA_W-1:0]        DATA_OUT,
    output logic                      OUTPUT_STROBE_P_OUT,
    output logic                      OUTPUT_STROBE_N_OUT,
    output logic                      STRAP_ILLEGAL_OUT,
    // Register read port.
    input  wire logic                 REG_RD_IN,
    input  wire logic [7:0]           REG_ADDR_IN,
    output logic [7:0]                REG_RDATA_OUT,
    output logic                      REG_RVALID_OUT
);

    // Synchroniser stages for asynchronous pins.
    logic [1:0]           sup_a_sync_ff;   // Analog supply good.
    logic [1:0]           sup_d_sync_ff;   // Digital supply good.
    logic [1:0]           recal_sync_ff;   // Recalibration line level.
    logic [1:0]           slip_sync_ff;    // Edge-skip request.
    logic [1:0]           strap0_sync_ff;  // Strap sense bit 0.
    logic [1:0]           strap1_sync_ff;  // Strap sense bit 1.

    // Edge history of synchronised levels.
    logic                 recal_prev_ff;   // Previous recal level.
    logic                 slip_prev_ff;    // Previous edge-skip level.

    // Sequencer state.
    seq_state_t           state_ff;        // Current state.
    seq_state_t           nxt_state;       // Next state.
    logic                 cal_done_ff;     // Calibration finished flag.

    // Strap capture after reset release.
    logic                 strap_taken_ff;  // Strap already captured.
    div_mode_t            div_mode_ff;     // Selected divide ratio.
    logic                 strap_ill_ff;    // Strap tied high.

    // Sample timing.
    logic                 div_phase_ff;    // Divider phase in divide-by-two.
    logic                 tick;            // One sample period elapsed.
    logic                 core_sel_ff;     // Core that takes the next sample.

    // Derived levels.
    logic                 recal_level;     // Synchronised line level.
    logic                 recal_rise;      // Line released.
    logic                 slip_pulse;      // Edge-skip request edge.
    logic                 supplies_ok;     // Both supplies good.
    logic [`SAMPLE_W-1:0] pipe_dout;       // Delayed sample.
    logic [7:0]           status_word;     // Status register contents.

    // Link to the calibration timer.
    cal_link_if           cal_link ();

    // Two-stage synchronisers on every asynchronous pin.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            sup_a_sync_ff  <= 2'h0;
            sup_d_sync_ff  <= 2'h0;
            recal_sync_ff  <= 2'h0;
            slip_sync_ff   <= 2'h0;
            strap0_sync_ff <= 2'h0;
            strap1_sync_ff <= 2'h0;
        end else begin
            sup_a_sync_ff  <= {sup_a_sync_ff[0], ANALOG_SUPPLY_OK_IN};
            sup_d_sync_ff  <= {sup_d_sync_ff[0], DIGITAL_SUPPLY_OK_IN};
            recal_sync_ff  <= {recal_sync_ff[0], RECAL_REQUEST_N_IN};
            slip_sync_ff   <= {slip_sync_ff[0], PHASE_SLIP_IN};
            strap0_sync_ff <= {strap0_sync_ff[0], DIVIDER_STRAP_IN[0]};
            strap1_sync_ff <= {strap1_sync_ff[0], DIVIDER_STRAP_IN[1]};
        end
    end

    // Only the second stages feed logic.
    assign recal_level = recal_sync_ff[1];
    assign supplies_ok = sup_a_sync_ff[1] & sup_d_sync_ff[1];
    assign recal_rise  = rise(recal_prev_ff, recal_level);
    assign slip_pulse  = rise(slip_prev_ff, slip_sync_ff[1]);

    // Edge history; reset as low so a line already high is seen as a release.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            recal_prev_ff <= 1'b0;
            slip_prev_ff  <= 1'b0;
        end else begin
            recal_prev_ff <= recal_level;
            slip_prev_ff  <= slip_sync_ff[1];
        end
    end

    // Captures the strap once, after reset release and synchronisation.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            strap_taken_ff <= 1'b0;
            div_mode_ff    <= DIV_BY1;
            strap_ill_ff   <= 1'b0;
        end else if (!strap_taken_ff && supplies_ok) begin
            strap_taken_ff <= 1'b1;
            // Tied low divides; floating passes; tied high is flagged.
            case ({strap1_sync_ff[1], strap0_sync_ff[1]})
                `STRAP_TIED_LOW: begin
                    div_mode_ff  <= DIV_BY2;
                    strap_ill_ff <= 1'b0;
                end
                `STRAP_FLOATING: begin
                    div_mode_ff  <= DIV_BY1;
                    strap_ill_ff <= 1'b0;
                end
                default: begin
                    div_mode_ff  <= DIV_BY1;
                    strap_ill_ff <= 1'b1;
                end
            endcase
        end
    end

    // Divider phase; in divide-by-two an edge-skip request holds the phase for one cycle.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            div_phase_ff <= 1'b0;
        end else if (div_mode_ff == DIV_BY2 && slip_pulse) begin
            div_phase_ff <= div_phase_ff;
        end else begin
            div_phase_ff <= ~div_phase_ff;
        end
    end

    // One sample per clock undivided, one per two clocks divided.
    assign tick = (div_mode_ff == DIV_BY1) ? 1'b1 : div_phase_ff;

    // Alternates sampling between the two cores on each sample edge.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            core_sel_ff       <= 1'b0;
            CORE_A_SAMPLE_OUT <= 1'b0;
            CORE_B_SAMPLE_OUT <= 1'b0;
        end else begin
            core_sel_ff       <= tick ? ~core_sel_ff : core_sel_ff;
            CORE_A_SAMPLE_OUT <= tick & ~core_sel_ff;
            CORE_B_SAMPLE_OUT <= tick & core_sel_ff;
        end
    end

    // Next state of the sequencer.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            // Line pulled low until supplies are good.
            ST_POR: begin
                if (supplies_ok) begin
                    nxt_state = ST_HOLD;
                end
            end
            // Waiting for the line to rise.
            ST_HOLD: begin
                if (recal_rise) begin
                    nxt_state = ST_CAL;
                end
            end
            // Calibration running; line low aborts it.
            ST_CAL: begin
                if (!recal_level) begin
                    nxt_state = ST_HOLD;
                end else if (cal_link.done) begin
                    nxt_state = ST_RUN;
                end
            end
            // Normal conversion; line low requests recalibration.
            ST_RUN: begin
                if (!recal_level) begin
                    nxt_state = ST_HOLD;
                end
            end
            default: begin
                nxt_state = ST_POR;
            end
        endcase
    end

    // State register.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            state_ff <= ST_POR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Timer requests follow the state decisions.
    assign cal_link.start = (state_ff == ST_HOLD) && recal_rise;
    assign cal_link.abort = (state_ff == ST_CAL) && cal_link.busy && !recal_level;

    // Device pulls the open-drain line low only during supply-up.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            RECAL_REQUEST_N_OUT    <= 1'b0;
            RECAL_REQUEST_N_OE_OUT <= 1'b1;
        end else begin
            RECAL_REQUEST_N_OUT    <= 1'b0;
            RECAL_REQUEST_N_OE_OUT <= (nxt_state == ST_POR);
        end
    end

    // Done flag: set by completion, cleared by a low line; set wins.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            cal_done_ff <= 1'b0;
        end else if (cal_link.done && state_ff == ST_CAL) begin
            cal_done_ff <= 1'b1;
        end else if (!recal_level || cal_link.start) begin
            cal_done_ff <= 1'b0;
        end
    end

    // Calibration timer.
    cal_timer #(
        .NOM_CYC (CAL_NOM_CYC),
        .MAX_CYC (CAL_MAX_CYC)
    ) u_cal_timer (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .link     (cal_link.timer)
    );

    // Conversion latency pipeline.
    sample_pipe u_sample_pipe (
        .clk_in     (CLK_IN),
        .rst_n_in   (RST_N_IN),
        .tick_in    (tick),
        .sample_in  (SAMPLE_IN),
        .sample_out (pipe_dout)
    );

    // Output data: pattern until calibration has finished.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            DATA_OUT <= `CAL_PATTERN;
        end else if (state_ff != ST_RUN) begin
            DATA_OUT <= `CAL_PATTERN;
        end else if (tick) begin
            DATA_OUT <= {{(`DATA_W - `SAMPLE_W){1'b0}}, pipe_dout};
        end
    end

    // Strobe pair: low while the line is low, toggling once it is released.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            OUTPUT_STROBE_P_OUT <= 1'b0;
            OUTPUT_STROBE_N_OUT <= 1'b1;
        end else if (!recal_level) begin
            OUTPUT_STROBE_P_OUT <= 1'b0;
            OUTPUT_STROBE_N_OUT <= 1'b1;
        end else if (tick) begin
            OUTPUT_STROBE_P_OUT <= ~OUTPUT_STROBE_P_OUT;
            OUTPUT_STROBE_N_OUT <= OUTPUT_STROBE_P_OUT;
        end
    end

    // Strap fault flag, one cycle behind its register.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            STRAP_ILLEGAL_OUT <= 1'b0;
        end else begin
            STRAP_ILLEGAL_OUT <= strap_ill_ff;
        end
    end

    // Status word; unused bits read as zero.
    always_comb begin
        status_word                 = `CAL_STATUS_RST;
        status_word[`CAL_DONE_BIT]  = cal_done_ff;
        status_word[`STRAP_ILL_BIT] = strap_ill_ff;
        status_word[`DIV2_MODE_BIT] = (div_mode_ff == DIV_BY2);
    end

    // Read port: answers one cycle after the request; unmapped reads zero.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            REG_RDATA_OUT  <= 8'h00;
            REG_RVALID_OUT <= 1'b0;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT  <= (REG_ADDR_IN == `CAL_STATUS_ADDR) ? status_word : 8'h00;
            REG_RVALID_OUT <= 1'b1;
        end else begin
            REG_RDATA_OUT  <= REG_RDATA_OUT;
            REG_RVALID_OUT <= 1'b0;
        end
    end

endmodule // adc_calibration_reset_seq

// File: dv/adc_seq_checker_assertions.sv
/*
 * Port-level assertions for the calibration reset sequencer.
 * Assumes one clock and the synchronous active-low reset of the top.
 */
`timescale 1ns/10ps
`include "adc_cal_cfg.svh"

module adc_seq_checker #(
    parameter int CAL_NOM_CYC = 50,
    parameter int CAL_MAX_CYC = 100
) (
    // Clock, reset and line inputs.
    input wire logic               CLK_IN,
    input wire logic               RST_N_IN,
    input wire logic               ANALOG_SUPPLY_OK_IN,
    input wire logic               DIGITAL_SUPPLY_OK_IN,
    input wire logic               RECAL_REQUEST_N_IN,
    input wire logic [1:0]         DIVIDER_STRAP_IN,
    input wire logic               REG_RD_IN,
    input wire logic [7:0]         REG_ADDR_IN,
    // Observed outputs.
    input wire logic               RECAL_REQUEST_N_OUT,
    input wire logic               RECAL_REQUEST_N_OE_OUT,
    input wire logic               CORE_A_SAMPLE_OUT,
    input wire logic               CORE_B_SAMPLE_OUT,
    input wire logic [`DATA_W-1:0] DATA_OUT,
    input wire logic               OUTPUT_STROBE_P_OUT,
    input wire logic               OUTPUT_STROBE_N_OUT,
    input wire logic [7:0]         REG_RDATA_OUT,
    input wire logic               REG_RVALID_OUT
);
    // Shorter of the two calibration times, which the design clamps to.
    localparam int CAL_CYC = (CAL_NOM_CYC < CAL_MAX_CYC) ? CAL_NOM_CYC : CAL_MAX_CYC;
    int cal_cnt_ff; // Cycles spent with the line high and the pattern shown.

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    // Counts calibration cycles; any low line or real data clears it.
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || !RECAL_REQUEST_N_IN || DATA_OUT != `CAL_PATTERN) begin
            cal_cnt_ff <= 0;
        end else begin
            cal_cnt_ff <= cal_cnt_ff + 1;
        end
    end

    a_hold_at_por: assert property ($rose(RST_N_IN) |-> RECAL_REQUEST_N_OE_OUT && !RECAL_REQUEST_N_OUT)
        else $error("line not held low after reset");
    a_release_supply: assert property ((ANALOG_SUPPLY_OK_IN && DIGITAL_SUPPLY_OK_IN) [*7] |-> !RECAL_REQUEST_N_OE_OUT)
        else $error("line still pulled with supplies good");
    a_strobe_low_recal: assert property (!RECAL_REQUEST_N_IN [*5] |-> !OUTPUT_STROBE_P_OUT && OUTPUT_STROBE_N_OUT)
        else $error("strobe not low while line low");
    a_strobe_pair_compl: assert property (OUTPUT_STROBE_P_OUT != OUTPUT_STROBE_N_OUT)
        else $error("strobe pair not complementary");
    a_strobe_toggle_run: assert property ((DIVIDER_STRAP_IN == 2'h1 && RECAL_REQUEST_N_IN) [*6] |-> OUTPUT_STROBE_P_OUT != $past(OUTPUT_STROBE_P_OUT))
        else $error("strobe not toggling");
    a_pattern_recal: assert property (!RECAL_REQUEST_N_IN [*5] |-> DATA_OUT == `CAL_PATTERN)
        else $error("pattern missing while line low");
    a_core_alternate: assert property (CORE_A_SAMPLE_OUT && DIVIDER_STRAP_IN == 2'h1 |=> CORE_B_SAMPLE_OUT && !CORE_A_SAMPLE_OUT)
        else $error("cores not alternating");
    a_read_answer: assert property (REG_RD_IN |=> REG_RVALID_OUT)
        else $error("read not answered");
    a_valid_cause: assert property (REG_RVALID_OUT |-> $past(REG_RD_IN))
        else $error("read valid without request");
    a_unmapped_zero: assert property (REG_RD_IN && REG_ADDR_IN != `CAL_STATUS_ADDR |=> REG_RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    a_done_in_run: assert property (REG_RD_IN && REG_ADDR_IN == `CAL_STATUS_ADDR && DATA_OUT != `CAL_PATTERN |=> REG_RDATA_OUT[0])
        else $error("done bit low with live data");
    a_cal_bound: assert property (cal_cnt_ff <= CAL_CYC + 8)
        else $error("calibration too long");
    a_cal_min: assert property ($past(DATA_OUT) == `CAL_PATTERN && DATA_OUT != `CAL_PATTERN |-> cal_cnt_ff >= CAL_CYC)
        else $error("calibration ended early");
endmodule // adc_seq_checker

bind adc_calibration_reset_seq adc_seq_checker #(.CAL_NOM_CYC(CAL_NOM_CYC), .CAL_MAX_CYC(CAL_MAX_CYC)) u_chk (
    .CLK_IN, .RST_N_IN, .ANALOG_SUPPLY_OK_IN, .DIGITAL_SUPPLY_OK_IN, .RECAL_REQUEST_N_IN,
    .DIVIDER_STRAP_IN, .REG_RD_IN, .REG_ADDR_IN, .RECAL_REQUEST_N_OUT, .RECAL_REQUEST_N_OE_OUT,
    .CORE_A_SAMPLE_OUT, .CORE_B_SAMPLE_OUT, .DATA_OUT, .OUTPUT_STROBE_P_OUT,
    .OUTPUT_STROBE_N_OUT, .REG_RDATA_OUT, .REG_RVALID_OUT);

// File: dv/host_recal_model.sv
/*
 * Host side of the open-drain recalibration line, with its pull-up.
 * Assumes the testbench calls pulse_low from its main sequence.
 */
`timescale 1ns/10ps

module host_recal_model (
    // Clock and device side of the line.
    input  wire logic clk_in,
    input  wire logic dev_oe_in,
    input  wire logic dev_val_in,
    // Resolved line level.
    output logic      line_out
);
    logic host_pull = 1'b0; // High while the host pulls the line low.

    // The pull-up wins unless either party pulls low.
    assign line_out = !((dev_oe_in && !dev_val_in) || host_pull);

    // Pulls low for n cycles, changing only after falling edges.
    task automatic pulse_low(input int n);
        @(negedge clk_in);
        host_pull = 1'b1;
        repeat (n) @(negedge clk_in);
        host_pull = 1'b0;
    endtask
endmodule // host_recal_model

// File: dv/adc_calibration_reset_seq_tb_top.sv
/*
 * Self-checking bench for the calibration reset sequencer.
 * Assumes the checker binds itself and the host model owns the line.
 */
`timescale 1ns/10ps
`include "adc_cal_cfg.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end

module adc_calibration_reset_seq_tb_top;
    localparam int NOM = 50;                     // Shortened calibration time.
    logic clk = 1'b0, rst_n = 1'b0, a_ok = 1'b0, d_ok = 1'b0, slip = 1'b0, rd_en = 1'b0;
    logic line, oe, rv, core_a, core_b, sp, sn, ill, rvalid, ph;
    logic [1:0]         strap = 2'h1;            // Divider strap sense.
    logic [11:0]        sample = 12'h000;        // Sample fed to the pipe.
    logic [11:0]        hist [60];               // Samples driven, by cycle.
    logic [7:0]         addr = 8'h00, rdata;     // Read port.
    logic [`DATA_W-1:0] data;                    // Output word.
    int                 n_errors = 0, check_count = 0, n;

    always #2.5 clk = ~clk;

    adc_calibration_reset_seq #(.CAL_NOM_CYC(NOM), .CAL_MAX_CYC(2 * NOM)) u_adc_calibration_reset_seq (
        .CLK_IN(clk), .RST_N_IN(rst_n), .ANALOG_SUPPLY_OK_IN(a_ok), .DIGITAL_SUPPLY_OK_IN(d_ok),
        .RECAL_REQUEST_N_IN(line), .RECAL_REQUEST_N_OUT(rv), .RECAL_REQUEST_N_OE_OUT(oe),
        .DIVIDER_STRAP_IN(strap), .PHASE_SLIP_IN(slip), .SAMPLE_IN(sample),
        .CORE_A_SAMPLE_OUT(core_a), .CORE_B_SAMPLE_OUT(core_b), .DATA_OUT(data),
        .OUTPUT_STROBE_P_OUT(sp), .OUTPUT_STROBE_N_OUT(sn), .STRAP_ILLEGAL_OUT(ill),
        .REG_RD_IN(rd_en), .REG_ADDR_IN(addr), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid));

    host_recal_model u_host_recal_model (.clk_in(clk), .dev_oe_in(oe), .dev_val_in(rv), .line_out(line));

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Expected status word for a strap setting and done state.
    function automatic logic [7:0] exp_status(input logic [1:0] s, input logic d);
        return {5'h00, s == 2'h0, s[1], d};
    endfunction

    // One read; the answer is checked in the cycle in which the valid pulse stands.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata)
    endtask

    // Waits, bounded, until live data replaces the pattern.
    task automatic wait_run(output int c);
        c = 0;
        while (data === `CAL_PATTERN) begin
            @(negedge clk);
            c++;
            if (c > 1000) begin
                n_errors++;
                report_and_stop();
            end
        end
    endtask

    // Power-up with one strap setting; no reads until calibration ends.
    task automatic session(input logic [1:0] s);
        rst_n = 1'b0;
        a_ok = 1'b0;
        d_ok = 1'b0;
        strap = s;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat ($urandom_range(2, 9)) @(negedge clk);
        a_ok = 1'b1;
        repeat ($urandom_range(0, 5)) @(negedge clk);
        d_ok = 1'b1;
        wait_run(n);
        `CHK("cal time", 1'b1, n >= NOM && n <= NOM + 14)
        `CHK("strap illegal", s[1], ill)
        rd(`CAL_STATUS_ADDR, exp_status(s, 1'b1));
    endtask

    initial begin
        void'($urandom(32'hAB93));
        session(2'h0);
        ph = core_a | core_b;
        slip = 1'b1;
        @(negedge clk);
        slip = 1'b0;
        repeat (7) @(negedge clk);
        `CHK("phase slip", ~ph, core_a | core_b)
        session(2'h2);
        session(2'h1);
        rd(8'($urandom_range(0, 8'hB5)), 8'h00);
        for (int i = 0; i < 60; i++) begin
            @(negedge clk);
            if (i >= 21) `CHK("data", {4'h0, hist[i - 21]}, data)
            hist[i] = 12'($urandom);
            sample = hist[i];
        end
        u_host_recal_model.pulse_low($urandom_range(6, 8));
        repeat (20) @(negedge clk);
        `CHK("pattern", `CAL_PATTERN, data)
        rd(`CAL_STATUS_ADDR, exp_status(2'h1, 1'b0));
        u_host_recal_model.pulse_low(3);
        wait_run(n);
        `CHK("restart", 1'b1, n >= NOM)
        rd(`CAL_STATUS_ADDR, exp_status(2'h1, 1'b1));
        report_and_stop();
    end
endmodule // adc_calibration_reset_seq_tb_top
